// ===== rtl/cdr_ctrl_pkg.sv
package cdr_ctrl_pkg;

   // Serial-bus subaddresses of the register bank
   localparam logic [7:0] SUB_REF_CONFIG_RB = 8'h05;
   localparam logic [7:0] SUB_ACQUIRE_RB    = 8'h06;
   localparam logic [7:0] SUB_REF_CONFIG    = 8'h08;
   localparam logic [7:0] SUB_ACQUIRE       = 8'h09;
   localparam logic [7:0] SUB_OUTPUT_CTRL   = 8'h11;
   localparam logic [7:0] SUB_OUTPUT_MODE   = 8'h22;

   // Value of every writable register after power-up
   localparam logic [7:0] CTRL_RESET_VAL    = 8'h00;

   // Reference configuration fields
   localparam int REF_BAND_HI   = 7;
   localparam int REF_BAND_LO   = 6;
   localparam int DIV_EXP_HI    = 5;
   localparam int DIV_EXP_LO    = 2;
   localparam int LOCK_REF_BIT  = 0;
   localparam logic [3:0] DIV_EXP_MAX = 4'h8;

   // Acquisition control field
   localparam int ACQ_START_BIT = 5;

   // Output control fields
   localparam int BUS_SWAP_BIT  = 5;
   localparam int PAR_HALF_BIT  = 4;
   localparam int PHASE_HI      = 3;
   localparam int PHASE_LO      = 2;
   localparam int BOOST_BIT     = 0;

   // Output mode fields
   localparam int SERIAL_BIT    = 7;
   localparam int DIS_DATA_BIT  = 6;
   localparam int DIS_CLK_BIT   = 5;
   localparam int SER_FULL_BIT  = 0;

   // Fixed upper five bits of the 7-bit slave address
   localparam logic [4:0] SLAVE_ADDR_FIXED = 5'h10;

   // Serial-bus byte framing
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] ACK_SLOT      = 4'h9;

   // Phase acquisition time, in UI, and its count of link clocks
   localparam int PREAMBLE_UI      = 12;
   localparam int UI_PER_LINK_CLK  = 1;
   localparam logic [3:0] PREAMBLE_CYC =
      4'(PREAMBLE_UI / UI_PER_LINK_CLK);

   // Serial-bus slave states
   typedef enum {
      ST_IDLE,
      ST_DEV,
      ST_SUB,
      ST_WR,
      ST_RD
   } bus_st_t;

   // Output configuration carried into the link clock domain
   typedef struct packed {
      logic bus_swap;
      logic par_half;
      logic serial;
      logic ser_full;
      logic dis_data;
      logic dis_clk;
   } link_cfg_t;

endpackage : cdr_ctrl_pkg

// ===== rtl/burst_cdr_control_registers.sv
`timescale 1ns/1ps

// What this block does
// - Writable registers read zero after power-up
// - First register bits 7:6 pick reference band
// - First register bits 5:2 give ratio 2^n, 2^8 for codes above 8
// - First register bit 0 selects lock source
// - Writing acquisition bit 1 then 0 starts acquisition
// - Output control bit 5 sets nibble bit order
// - Output control bit 4 sets parallel clock rate
// - Output control bits 3:2 shift recovered clock edge
// - Output control bit 0 boosts output swing
// - Mode bit 7 serial/parallel, bit 0 serial clock
// - Mode bit 6 disables data output buffer
// - Mode bit 5 disables clock output buffer
// - Data-valid output is active low
// - Squelch high suppresses data and clock outputs
// - Nibble msb on top line, lsb bottom
// - Two strap pins give address bits 2:1
// - Address top bit one, bits 6:3 zero
// - Valid 12 UI into preamble until reset
// - Squelch holds clock and data outputs zero
// - Invalid subaddress gets no acknowledge, idle
module burst_cdr_control_registers (
   // Core clock and reset
   input  wire logic       CORE_CLK_I,
   input  wire logic       ARST_N_I,
   // Serial-bus pins, data line split for open drain
   input  wire logic       SCK_I,
   input  wire logic       SDA_I,
   output logic            SDA_O,
   output logic            SDA_OE_N_O,
   // Address strap pins
   input  wire logic       SLAVE_ADDR_STRAP_HI_I,
   input  wire logic       SLAVE_ADDR_STRAP_LO_I,
   // Loop controls toward the analog core
   output logic [1:0]      REF_BAND_O,
   output logic [8:0]      DIV_RATIO_O,
   output logic            LOCK_TO_REF_O,
   output logic            ACQ_START_O,
   output logic [1:0]      RECOVERED_CLOCK_PHASE_PHASE_O,
   output logic            OUTPUT_BOOST_O,
   // Link side: recovered clock, data and burst pins
   input  wire logic       LINK_CLK_I,
   input  wire logic       SER_DATA_I,
   input  wire logic       BURST_RESET_I,
   input  wire logic       SQUELCH_I,
   // Link side outputs
   output logic [3:0]      NIBBLE_O,
   output logic            SER_DATA_O,
   output logic            CLK_OUT_O,
   output logic            BURST_VALID_N_O
);

   // Pin synchronisers in the core domain
   logic                   scl_meta_r;       // First stage, clock pin
   logic                   scl_s_r;          // Synchronised clock pin
   logic                   scl_d_r;          // Previous synchronised clock
   logic                   sda_meta_r;       // First stage, data pin
   logic                   sda_s_r;          // Synchronised data pin
   logic                   sda_d_r;          // Previous synchronised data
   logic [1:0]             strap_meta_r;     // First stage, straps
   logic [1:0]             strap_s_r;        // Synchronised straps

   // Bus events
   logic                   start_ev;         // Start condition seen
   logic                   stop_ev;          // Stop condition seen
   logic                   scl_rise;         // Clock line rose
   logic                   scl_fall;         // Clock line fell
   logic                   wr_en;            // Data byte complete in write

   // Slave state
   cdr_ctrl_pkg::bus_st_t  st_r;             // Bus slave state
   logic [3:0]             bit_cnt_r;        // Bits of the byte, then ack
   logic [7:0]             shift_r;          // Received byte
   logic [7:0]             tx_r;             // Byte being sent
   logic [7:0]             sub_r;            // Current subaddress
   logic [7:0]             sub_nxt;          // Autoincremented subaddress
   logic [7:0]             rd_nxt;           // Byte at the next subaddress
   logic [7:0]             rd_cur;           // Byte at the current one
   logic                   rd_dir_r;         // Read requested in address
   logic                   nack_r;           // Master refused the byte
   logic                   sda_rel_r;        // Data line released

   // Control registers
   logic [7:0]             ref_config_r;     // Reference configuration
   logic [7:0]             acquire_r;        // Acquisition control
   logic [7:0]             outctl_r;         // Output control
   logic [7:0]             mode_r;           // Output mode
   logic                   acq_start_r;      // Acquisition start pulse
   logic [8:0]             div_ratio_r;      // Decoded divide ratio

   // Link domain
   logic [1:0]             lrst_r;           // Link reset release chain
   logic                   lrst_n;           // Link domain reset
   cdr_ctrl_pkg::link_cfg_t cfg_core;        // Config in core domain
   cdr_ctrl_pkg::link_cfg_t cfg_meta_r;      // First stage, config
   cdr_ctrl_pkg::link_cfg_t cfg_s_r;         // Config in link domain
   logic                   br_meta_r;        // First stage, burst reset
   logic                   br_s_r;           // Synchronised burst reset
   logic                   sq_meta_r;        // First stage, squelch
   logic                   sq_s_r;           // Synchronised squelch
   logic                   prev_bit_r;       // Previous received bit
   logic [3:0]             alt_cnt_r;        // Alternating bits so far
   logic                   locked_r;         // Phase acquired
   logic [1:0]             phase_r;          // Bit slot within the nibble
   logic [3:0]             sh_r;             // Nibble being assembled
   logic [3:0]             nibble_r;         // Last complete nibble
   logic [3:0]             sh_nxt;           // Nibble with the new bit
   logic                   nib_tgl_r;        // Toggles once per nibble
   logic [2:0]             ui_cnt_r;         // Free UI counter
   logic                   valid_n_r;        // Data valid, active low
   logic [3:0]             nib_out_r;        // Registered nibble output
   logic                   ser_out_r;        // Registered serial output
   logic                   clk_out_r;        // Registered clock output

   // Two-flop synchronisers for the bus and strap pins
   always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         scl_meta_r   <= 1'b1;
         scl_s_r      <= 1'b1;
         scl_d_r      <= 1'b1;
         sda_meta_r   <= 1'b1;
         sda_s_r      <= 1'b1;
         sda_d_r      <= 1'b1;
         strap_meta_r <= 2'h0;
         strap_s_r    <= 2'h0;
      end else begin
         scl_meta_r   <= SCK_I;
         scl_s_r      <= scl_meta_r;
         scl_d_r      <= scl_s_r;
         sda_meta_r   <= SDA_I;
         sda_s_r      <= sda_meta_r;
         sda_d_r      <= sda_s_r;
         // Straps follow the pin levels
         strap_meta_r <= {SLAVE_ADDR_STRAP_HI_I, SLAVE_ADDR_STRAP_LO_I};
         strap_s_r    <= strap_meta_r;
      end
   end

   // Bus conditions from the synchronised lines
   assign start_ev = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
   assign stop_ev  = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;
   assign scl_rise = scl_s_r & ~scl_d_r;
   assign scl_fall = ~scl_s_r & scl_d_r;
   assign wr_en    = (st_r == cdr_ctrl_pkg::ST_WR) & scl_fall &
                     (bit_cnt_r == cdr_ctrl_pkg::BITS_PER_BYTE) &
                     ~start_ev & ~stop_ev;

   // Readback multiplexer for a subaddress
   function automatic logic [7:0] rd_byte(input logic [7:0] sub);
      case (sub)
         cdr_ctrl_pkg::SUB_REF_CONFIG_RB: rd_byte = ref_config_r;
         cdr_ctrl_pkg::SUB_ACQUIRE_RB:    rd_byte = acquire_r;
         default:                         rd_byte = 8'h00;
      endcase
   endfunction : rd_byte

   // Subaddress check
   function automatic logic sub_ok(input logic [7:0] sub);
      sub_ok = (sub == cdr_ctrl_pkg::SUB_REF_CONFIG_RB) ||
               (sub == cdr_ctrl_pkg::SUB_ACQUIRE_RB) ||
               (sub == cdr_ctrl_pkg::SUB_REF_CONFIG) ||
               (sub == cdr_ctrl_pkg::SUB_ACQUIRE) ||
               (sub == cdr_ctrl_pkg::SUB_OUTPUT_CTRL) ||
               (sub == cdr_ctrl_pkg::SUB_OUTPUT_MODE);
   endfunction : sub_ok

   // Autoincrement stops at the highest subaddress
   always_comb begin
      if (sub_r >= cdr_ctrl_pkg::SUB_OUTPUT_MODE) begin
         sub_nxt = cdr_ctrl_pkg::SUB_OUTPUT_MODE;
      end else begin
         sub_nxt = sub_r + 8'h01;
      end
      rd_nxt = rd_byte(sub_nxt);
      rd_cur = rd_byte(sub_r);
   end

   // Bus slave: framing, acknowledge and data line drive
   always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         st_r      <= cdr_ctrl_pkg::ST_IDLE;
         bit_cnt_r <= 4'h0;
         shift_r   <= 8'h00;
         tx_r      <= 8'h00;
         sub_r     <= 8'h00;
         rd_dir_r  <= 1'b0;
         nack_r    <= 1'b0;
         sda_rel_r <= 1'b1;
      end else if (stop_ev) begin
         // Stop anywhere returns to idle
         st_r      <= cdr_ctrl_pkg::ST_IDLE;
         sda_rel_r <= 1'b1;
      end else if (start_ev) begin
         // Start anywhere begins a new address byte
         st_r      <= cdr_ctrl_pkg::ST_DEV;
         bit_cnt_r <= 4'h0;
         sda_rel_r <= 1'b1;
      end else if (st_r != cdr_ctrl_pkg::ST_IDLE) begin
         if (scl_rise) begin
            if (bit_cnt_r < cdr_ctrl_pkg::BITS_PER_BYTE) begin
               // Bits arrive msb first
               shift_r   <= {shift_r[6:0], sda_s_r};
               bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (bit_cnt_r == cdr_ctrl_pkg::BITS_PER_BYTE) begin
               // Ninth clock: sample the master's acknowledge
               nack_r    <= sda_s_r;
               bit_cnt_r <= cdr_ctrl_pkg::ACK_SLOT;
            end
         end else if (scl_fall) begin
            if (bit_cnt_r == cdr_ctrl_pkg::BITS_PER_BYTE) begin
               // Byte done: decide the acknowledge
               case (st_r)
                  cdr_ctrl_pkg::ST_DEV: begin
                     if (shift_r[7:1] == {cdr_ctrl_pkg::SLAVE_ADDR_FIXED,
                                          strap_s_r}) begin
                        sda_rel_r <= 1'b0;
                        rd_dir_r  <= shift_r[0];
                     end else begin
                        st_r <= cdr_ctrl_pkg::ST_IDLE;
                     end
                  end
                  cdr_ctrl_pkg::ST_SUB: begin
                     if (sub_ok(shift_r)) begin
                        sda_rel_r <= 1'b0;
                        sub_r     <= shift_r;
                     end else begin
                        st_r <= cdr_ctrl_pkg::ST_IDLE;
                     end
                  end
                  cdr_ctrl_pkg::ST_WR: begin
                     sda_rel_r <= 1'b0;
                  end
                  cdr_ctrl_pkg::ST_RD: begin
                     // Release so the master can answer
                     sda_rel_r <= 1'b1;
                  end
                  default: begin
                     st_r <= cdr_ctrl_pkg::ST_IDLE;
                  end
               endcase
            end else if (bit_cnt_r == cdr_ctrl_pkg::ACK_SLOT) begin
               // End of the ninth clock: next byte
               bit_cnt_r <= 4'h0;
               sda_rel_r <= 1'b1;
               case (st_r)
                  cdr_ctrl_pkg::ST_DEV: begin
                     if (rd_dir_r) begin
                        st_r      <= cdr_ctrl_pkg::ST_RD;
                        tx_r      <= {rd_cur[6:0], 1'b0};
                        sda_rel_r <= rd_cur[7];
                     end else begin
                        st_r <= cdr_ctrl_pkg::ST_SUB;
                     end
                  end
                  cdr_ctrl_pkg::ST_SUB: begin
                     st_r <= cdr_ctrl_pkg::ST_WR;
                  end
                  cdr_ctrl_pkg::ST_WR: begin
                     sub_r <= sub_nxt;
                  end
                  cdr_ctrl_pkg::ST_RD: begin
                     if (nack_r) begin
                        st_r <= cdr_ctrl_pkg::ST_IDLE;
                     end else begin
                        sub_r     <= sub_nxt;
                        tx_r      <= {rd_nxt[6:0], 1'b0};
                        sda_rel_r <= rd_nxt[7];
                     end
                  end
                  default: begin
                     st_r <= cdr_ctrl_pkg::ST_IDLE;
                  end
               endcase
            end else if (st_r == cdr_ctrl_pkg::ST_RD) begin
               // Drive the next read bit
               sda_rel_r <= tx_r[7];
               tx_r      <= {tx_r[6:0], 1'b0};
            end
         end
      end
   end

   // Open-drain data line: drive low only
   assign SDA_O      = 1'b0;
   assign SDA_OE_N_O = sda_rel_r;

   // Control register writes; all start at zero
   always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         ref_config_r <= cdr_ctrl_pkg::CTRL_RESET_VAL;
         acquire_r    <= cdr_ctrl_pkg::CTRL_RESET_VAL;
         outctl_r     <= cdr_ctrl_pkg::CTRL_RESET_VAL;
         mode_r       <= cdr_ctrl_pkg::CTRL_RESET_VAL;
      end else if (wr_en) begin
         case (sub_r)
            cdr_ctrl_pkg::SUB_REF_CONFIG:  ref_config_r <= shift_r;
            cdr_ctrl_pkg::SUB_ACQUIRE:     acquire_r    <= shift_r;
            cdr_ctrl_pkg::SUB_OUTPUT_CTRL: outctl_r     <= shift_r;
            cdr_ctrl_pkg::SUB_OUTPUT_MODE: mode_r       <= shift_r;
            default: begin
               // Readback addresses ignore writes
            end
         endcase
      end
   end

   // Acquisition starts on a one-to-zero write of the start bit
   always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         acq_start_r <= 1'b0;
      end else begin
         acq_start_r <= wr_en &
            (sub_r == cdr_ctrl_pkg::SUB_ACQUIRE) &
            acquire_r[cdr_ctrl_pkg::ACQ_START_BIT] &
            ~shift_r[cdr_ctrl_pkg::ACQ_START_BIT];
      end
   end

   // Divide ratio is two to the exponent; larger codes saturate
   always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         div_ratio_r <= 9'h001;
      end else if (ref_config_r[cdr_ctrl_pkg::DIV_EXP_HI:
                                cdr_ctrl_pkg::DIV_EXP_LO] >
                   cdr_ctrl_pkg::DIV_EXP_MAX) begin
         div_ratio_r <= 9'h100;
      end else begin
         div_ratio_r <= 9'h001 << ref_config_r[cdr_ctrl_pkg::DIV_EXP_HI:
                                              cdr_ctrl_pkg::DIV_EXP_LO];
      end
   end

   // Loop controls come straight from register bits, except the decoded ratio and the start pulse flops
   assign REF_BAND_O     = ref_config_r[cdr_ctrl_pkg::REF_BAND_HI:
                                        cdr_ctrl_pkg::REF_BAND_LO];
   assign DIV_RATIO_O    = div_ratio_r;
   assign LOCK_TO_REF_O  = ref_config_r[cdr_ctrl_pkg::LOCK_REF_BIT];
   assign ACQ_START_O    = acq_start_r;
   assign RECOVERED_CLOCK_PHASE_PHASE_O  = outctl_r[cdr_ctrl_pkg::PHASE_HI:
                                    cdr_ctrl_pkg::PHASE_LO];
   assign OUTPUT_BOOST_O = outctl_r[cdr_ctrl_pkg::BOOST_BIT];

   // Output configuration gathered for the link domain
   always_comb begin
      cfg_core.bus_swap = outctl_r[cdr_ctrl_pkg::BUS_SWAP_BIT];
      cfg_core.par_half = outctl_r[cdr_ctrl_pkg::PAR_HALF_BIT];
      cfg_core.serial   = mode_r[cdr_ctrl_pkg::SERIAL_BIT];
      cfg_core.ser_full = mode_r[cdr_ctrl_pkg::SER_FULL_BIT];
      cfg_core.dis_data = mode_r[cdr_ctrl_pkg::DIS_DATA_BIT];
      cfg_core.dis_clk  = mode_r[cdr_ctrl_pkg::DIS_CLK_BIT];
   end

   // Reset release synchronised to the link clock
   always_ff @(posedge LINK_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         lrst_r <= 2'h0;
      end else begin
         lrst_r <= {lrst_r[0], 1'b1};
      end
   end
   assign lrst_n = lrst_r[1];

   // Quasi-static config and pin levels cross by two flops
   always_ff @(posedge LINK_CLK_I or negedge lrst_n) begin
      if (!lrst_n) begin
         cfg_meta_r <= '0;
         cfg_s_r    <= '0;
         br_meta_r  <= 1'b1;
         br_s_r     <= 1'b1;
         sq_meta_r  <= 1'b0;
         sq_s_r     <= 1'b0;
      end else begin
         cfg_meta_r <= cfg_core;
         cfg_s_r    <= cfg_meta_r;
         br_meta_r  <= BURST_RESET_I;
         br_s_r     <= br_meta_r;
         sq_meta_r  <= SQUELCH_I;
         sq_s_r     <= sq_meta_r;
      end
   end

   // New bit placed by the bus order setting
   always_comb begin
      if (cfg_s_r.bus_swap) begin
         sh_nxt = {SER_DATA_I, sh_r[3:1]};
      end else begin
         sh_nxt = {sh_r[2:0], SER_DATA_I};
      end
   end

   // Preamble search, data-valid and nibble assembly
   always_ff @(posedge LINK_CLK_I or negedge lrst_n) begin
      if (!lrst_n) begin
         prev_bit_r <= 1'b0;
         alt_cnt_r  <= 4'h0;
         locked_r   <= 1'b0;
         valid_n_r  <= 1'b1;
         phase_r    <= 2'h0;
         sh_r       <= 4'h0;
         nibble_r   <= 4'h0;
         nib_tgl_r  <= 1'b0;
      end else begin
         prev_bit_r <= SER_DATA_I;
         if (br_s_r) begin
            // Burst reset drops valid and rearms the search
            alt_cnt_r <= 4'h0;
            locked_r  <= 1'b0;
            valid_n_r <= 1'b1;
            phase_r   <= 2'h0;
         end else if (!locked_r) begin
            if (SER_DATA_I == prev_bit_r) begin
               alt_cnt_r <= 4'h0;
            end else if (alt_cnt_r == cdr_ctrl_pkg::PREAMBLE_CYC - 4'h1) begin
               locked_r  <= 1'b1;
               valid_n_r <= 1'b0;
            end else begin
               alt_cnt_r <= alt_cnt_r + 4'h1;
            end
         end else begin
            // Four bits per nibble once phase is held
            sh_r    <= sh_nxt;
            phase_r <= phase_r + 2'h1;
            if (phase_r == 2'h3) begin
               nibble_r  <= sh_nxt;
               nib_tgl_r <= ~nib_tgl_r;
            end
         end
      end
   end

   // Free running UI counter for the serial clock
   always_ff @(posedge LINK_CLK_I or negedge lrst_n) begin
      if (!lrst_n) begin
         ui_cnt_r <= 3'h0;
      end else begin
         ui_cnt_r <= ui_cnt_r + 3'h1;
      end
   end

   // Output stage: mode select, buffer disables and squelch
   always_ff @(posedge LINK_CLK_I or negedge lrst_n) begin
      if (!lrst_n) begin
         nib_out_r <= 4'h0;
         ser_out_r <= 1'b0;
         clk_out_r <= 1'b0;
      end else begin
         if (sq_s_r || cfg_s_r.dis_data) begin
            nib_out_r <= 4'h0;
            ser_out_r <= 1'b0;
         end else if (cfg_s_r.serial) begin
            nib_out_r <= 4'h0;
            ser_out_r <= SER_DATA_I;
         end else begin
            nib_out_r <= nibble_r;
            ser_out_r <= 1'b0;
         end
         if (sq_s_r || cfg_s_r.dis_clk) begin
            clk_out_r <= 1'b0;
         end else if (cfg_s_r.serial) begin
            clk_out_r <= cfg_s_r.ser_full ? ui_cnt_r[0]
                                          : ui_cnt_r[1];
         end else begin
            clk_out_r <= cfg_s_r.par_half ? nib_tgl_r
                                          : phase_r[1];
         end
      end
   end

   // Link outputs come from flops
   assign NIBBLE_O        = nib_out_r;
   assign SER_DATA_O      = ser_out_r;
   assign CLK_OUT_O       = clk_out_r;
   assign BURST_VALID_N_O = valid_n_r;

endmodule : burst_cdr_control_registers

// ===== verification/burst_cdr_control_registers_asserts.sv
`timescale 1ns/1ps
module burst_cdr_control_registers_asserts (
   // Clocks and reset
   input wire logic CORE_CLK_I,
   input wire logic LINK_CLK_I,
   input wire logic ARST_N_I,
   // Watched pins
   input wire logic SCK_I,
   input wire logic SDA_OE_N_O,
   input wire logic [8:0] DIV_RATIO_O,
   input wire logic ACQ_START_O,
   input wire logic SER_DATA_I,
   input wire logic BURST_RESET_I,
   input wire logic SQUELCH_I,
   input wire logic [3:0] NIBBLE_O,
   input wire logic CLK_OUT_O,
   input wire logic BURST_VALID_N_O
);
   // Burst reset low long enough to pass its sync
   sequence quiet_s;
      !BURST_RESET_I [*4];
   endsequence
   acq_pulse_a: assert property (@(posedge CORE_CLK_I)
      disable iff (!ARST_N_I) ACQ_START_O |=> !ACQ_START_O)
      else $error("start pulse too long");
   cfg_change_a: assert property (@(posedge CORE_CLK_I)
      disable iff (!ARST_N_I) !$stable(DIV_RATIO_O) |->
      !SCK_I && $onehot(DIV_RATIO_O)) else $error("bad ratio");
   sda_fall_a: assert property (@(posedge CORE_CLK_I)
      disable iff (!ARST_N_I) $fell(SDA_OE_N_O) |-> !SCK_I)
      else $error("data pulled while clock high");
   sda_rise_a: assert property (@(posedge CORE_CLK_I)
      disable iff (!ARST_N_I) $rose(SDA_OE_N_O) |-> !SCK_I)
      else $error("data freed while clock high");
   squelch_zero_a: assert property (@(posedge LINK_CLK_I)
      disable iff (!ARST_N_I) SQUELCH_I [*4] |->
      NIBBLE_O == 4'h0 && !CLK_OUT_O) else $error("not squelched");
   valid_drop_a: assert property (@(posedge LINK_CLK_I)
      disable iff (!ARST_N_I) BURST_RESET_I [*4] |-> BURST_VALID_N_O)
      else $error("valid during reset");
   valid_hold_a: assert property (@(posedge LINK_CLK_I)
      disable iff (!ARST_N_I) quiet_s ##0 !BURST_VALID_N_O |=>
      !BURST_VALID_N_O) else $error("valid dropped");
   valid_lock_a: assert property (@(posedge LINK_CLK_I)
      disable iff (!ARST_N_I) $fell(BURST_VALID_N_O) |->
      $past(SER_DATA_I) != $past(SER_DATA_I, 2)) else $error("bad lock");
endmodule : burst_cdr_control_registers_asserts
bind burst_cdr_control_registers burst_cdr_control_registers_asserts chk (.*);

// ===== verification/burst_source.sv
`timescale 1ns/1ps
module burst_source (
   // Link clock and burst pins
   input wire logic clk_i,
   output logic data_o = 1'b0,
   output logic rst_o = 1'b0
);
   // Preamble bits alternate every UI
   always @(posedge clk_i) data_o <= ~data_o;
   // Burst reset pulse of 16 UI ahead of a burst
   task pulse();
      rst_o <= 1'b1;
      repeat (16) @(posedge clk_i);
      rst_o <= 1'b0;
   endtask : pulse
endmodule : burst_source

// ===== verification/burst_cdr_control_registers_test.sv
`timescale 1ns/1ps
module burst_cdr_control_registers_test;
   // Pins, bus state and counters
   logic CORE_CLK_I = 0, ARST_N_I = 0, SCK_I = 1, sda_m = 1;
   logic LINK_CLK_I = 0, SQUELCH_I = 0, SER_DATA_I, BURST_RESET_I;
   logic SDA_O, SDA_OE_N_O, LOCK_TO_REF_O, ACQ_START_O, OUTPUT_BOOST_O;
   logic SER_DATA_O, CLK_OUT_O, BURST_VALID_N_O, a;
   logic [1:0] REF_BAND_O, RECOVERED_CLOCK_PHASE_PHASE_O;
   logic [8:0] DIV_RATIO_O;
   logic [3:0] NIBBLE_O;
   logic [7:0] q, v;
   int err_count = 0, comparisons = 0, acq_n = 0;
   wire SDA_I = sda_m & SDA_OE_N_O; // Open drain with pull-up
   initial forever #20 CORE_CLK_I = ~CORE_CLK_I;
   initial begin
      #7;
      forever #80 LINK_CLK_I = ~LINK_CLK_I;
   end
   always @(posedge CORE_CLK_I) acq_n += ACQ_START_O;
   burst_cdr_control_registers uut (.CORE_CLK_I, .ARST_N_I, .SCK_I, .SDA_I,
      .SDA_O, .SDA_OE_N_O, .SLAVE_ADDR_STRAP_HI_I(1'b1),
      .SLAVE_ADDR_STRAP_LO_I(1'b0), .REF_BAND_O, .DIV_RATIO_O, .LOCK_TO_REF_O,
      .ACQ_START_O, .RECOVERED_CLOCK_PHASE_PHASE_O, .OUTPUT_BOOST_O, .LINK_CLK_I, .SER_DATA_I,
      .BURST_RESET_I, .SQUELCH_I, .NIBBLE_O, .SER_DATA_O, .CLK_OUT_O,
      .BURST_VALID_N_O);
   burst_source src (.clk_i(LINK_CLK_I), .data_o(SER_DATA_I),
      .rst_o(BURST_RESET_I));
   task tk(int n);
      repeat (n) @(posedge CORE_CLK_I);
      #1;
   endtask : tk
   task lk(int n);
      repeat (n) @(posedge LINK_CLK_I);
      #1;
   endtask : lk
   // One bus bit, read back at the end of clock high
   task bb(input logic b, output logic r);
      sda_m = b;
      tk(10);
      SCK_I = 1;
      tk(10);
      r = SDA_I;
      SCK_I = 0;
      tk(10);
   endtask : bb
   // Byte msb first, then the acknowledge slot
   task xb(input logic [7:0] d, output logic [7:0] r, output logic k);
      for (int i = 7; i >= 0; i--) bb(d[i], r[i]);
      bb(1'b1, k);
      k = ~k;
   endtask : xb
   // Start when st is 1, stop when 0
   task cond(input logic st);
      sda_m = st;
      tk(10);
      SCK_I = 1;
      tk(10);
      sda_m = ~st;
      tk(10);
      if (st) SCK_I = 0;
      tk(10);
   endtask : cond
   task wr(input logic [7:0] dv, s, d, output logic ok);
      logic k1, k2, k3;
      cond(1);
      xb(dv, q, k1);
      xb(s, q, k2);
      xb(d, q, k3);
      cond(0);
      ok = k1 & k2 & k3;
   endtask : wr
   task rd(input logic [7:0] s, output logic [7:0] d);
      cond(1);
      xb(8'h84, q, a);
      xb(s, q, a);
      cond(1);
      xb(8'h85, q, a);
      xb(8'hFF, d, a);
      cond(0);
   endtask : rd
   task chk(input logic [8:0] g, e);
      comparisons++;
      if (g !== e) begin
         err_count++;
         $display("wrong value at %0t: %h not %h", $time, g, e);
      end
   endtask : chk
   task test_done();
      $display("compares %0d, mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : test_done
   initial begin
      #2000000;
      err_count++;
      test_done();
   end
   initial begin
      tk(16);
      ARST_N_I = 1;
      tk(4);
      chk(DIV_RATIO_O, 9'h001);
      rd(8'h06, q);
      chk(q, 9'h000);
      for (int n = 0; n < 9; n++) begin
         v = {n[1:0], n[3:0], 1'b0, n[0]};
         wr(8'h84, 8'h08, v, a);
         chk(REF_BAND_O, v[7:6]);
         chk(DIV_RATIO_O, 9'h001 << n);
         chk(LOCK_TO_REF_O, v[0]);
         rd(8'h05, q);
         chk(q, v);
      end
      wr(8'h84, 8'h09, 8'h20, a);
      rd(8'h06, q);
      chk(q, 9'h020);
      chk(acq_n, 0);
      wr(8'h84, 8'h09, 8'h00, a);
      chk(acq_n, 1);
      for (int p = 0; p < 4; p++) begin
         wr(8'h84, 8'h11, {4'h0, p[1:0], 1'b0, p[0]}, a);
         chk(RECOVERED_CLOCK_PHASE_PHASE_O, p[1:0]);
         chk(OUTPUT_BOOST_O, p[0]);
      end
      $display("register tests done");
      wr(8'h84, 8'h07, 8'h00, a);
      chk(a, 0);
      wr(8'h86, 8'h11, 8'h00, a);
      chk(a, 0);
      chk(OUTPUT_BOOST_O, 1);
      wr(8'h84, 8'h22, 8'h00, a);
      chk(a, 1);
      $display("address tests done");
      src.pulse();
      lk(40);
      chk(BURST_VALID_N_O, 0);
      chk(NIBBLE_O == 4'hA || NIBBLE_O == 4'h5, 1);
      v = NIBBLE_O;
      wr(8'h84, 8'h11, 8'h20, a);
      lk(8);
      chk(NIBBLE_O ^ v, 4'hF);
      SQUELCH_I = 1;
      lk(6);
      chk({NIBBLE_O, CLK_OUT_O}, 0);
      SQUELCH_I = 0;
      fork
         src.pulse();
         begin
            lk(8);
            chk(BURST_VALID_N_O, 1);
         end
      join
      wr(8'h84, 8'h22, 8'hE1, a);
      lk(8);
      chk({NIBBLE_O, SER_DATA_O, CLK_OUT_O}, 0);
      $display("link tests done");
      test_done();
   end
endmodule : burst_cdr_control_registers_test
